// ===== verilog/rpm_pkg.sv
// ==========================================================================
// shared constants for reset and power mode control
package rpm_pkg;

   // ========================================================================
   // register map: printed offsets are indices, byte address is index * 4
   localparam int         ADDR_W            = 12;
   localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
   localparam logic [7:0] IDX_SUPPLY_MON    = 8'hff;
   localparam logic [7:0] IDX_RESET_SOURCE  = 8'h90;
   localparam logic [7:0] IDX_IRQ_STATUS    = 8'h91;
   localparam logic [7:0] IDX_IRQ_ENABLE    = 8'h92;
   localparam logic [7:0] IDX_IRQ_CLEAR     = 8'h93;

   // ========================================================================
   // field positions
   localparam int PC_IDLE_BIT  = 0;
   localparam int PC_STOP_BIT  = 1;
   localparam int PC_FLAGS_LSB = 2;
   localparam int PC_FLAGS_W   = 6;
   localparam int RS_POR_BIT   = 1;
   localparam int SM_EN_BIT    = 7;
   localparam int SM_STAT_BIT  = 6;
   localparam int IRQ_W        = 3;
   localparam int IRQ_POR_DONE = 0;
   localparam int IRQ_MON_RST  = 1;
   localparam int IRQ_IDLE_WK  = 2;

   // ========================================================================
   // reset values and bus answers
   localparam logic [PC_FLAGS_W-1:0] FLAGS_RST    = 6'h00;
   localparam logic [IRQ_W-1:0]      IRQ_RST      = 3'h0;
   localparam logic [15:0]           RESET_VECTOR = 16'h0000;
   localparam logic [1:0]            AXI_OKAY     = 2'h0;
   localparam logic [1:0]            AXI_SLVERR   = 2'h2;

   // ========================================================================
   // timing: longest delay rounds down to whole cycles
   localparam int CLK_FREQ_HZ       = 40_000_000;
   localparam int POR_DELAY_US      = 10_000;
   localparam int POR_DELAY_CYCLES  = POR_DELAY_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int WDT_DIV           = 12;

   typedef enum logic [2:0] {
      ST_POR_WAIT, ST_POR_DELAY, ST_RUN, ST_IDLE, ST_STOP, ST_MON_RESET, ST_SW_RESET
   } pwr_state_t;

   // byte address to register index
   function automatic logic [7:0] regIndex(input logic [ADDR_W-1:0] addr);
      return addr[9:2];
   endfunction

   // true when a byte address hits a register
   function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
      logic [7:0] idx;
      idx = addr[9:2];
      return (addr[ADDR_W-1:10] == 2'h0) &&
             (idx == IDX_POWER_CONTROL || idx == IDX_SUPPLY_MON ||
              idx == IDX_RESET_SOURCE || idx == IDX_IRQ_STATUS ||
              idx == IDX_IRQ_ENABLE || idx == IDX_IRQ_CLEAR);
   endfunction

endpackage

// ===== verilog/tick_divider.sv
`timescale 1ns/1ps
// ==========================================================================
// one-cycle enable pulse every DIV cycles while enabled
module tick_divider import rpm_pkg::*; #(
   parameter int DIV = WDT_DIV
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic arst_n,
   // control
   input  wire logic en,
   output wire logic tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } div_state_t;

   localparam div_state_t DIV_RST = '{cnt: 8'h00, tick: 1'b0};
   localparam logic [7:0] LAST    = 8'(DIV - 1);

   div_state_t s, next_s;

   // count restarts whenever the divider is disabled
   always_comb begin
      next_s      = s;
      next_s.tick = 1'b0;
      if (!en) begin
         next_s.cnt = 8'h00;
      end else if (s.cnt == LAST) begin
         next_s.cnt  = 8'h00;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s <= DIV_RST;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;
endmodule // tick_divider

// ===== verilog/release_timer.sv
`timescale 1ns/1ps
// ==========================================================================
// one-shot delay: done rises CYCLES cycles after load
module release_timer #(
   parameter int CYCLES = 400000
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic arst_n,
   // control
   input  wire logic load,
   output wire logic done
);
   typedef struct packed {
      logic [31:0] cnt;
      logic        done;
   } tmr_state_t;

   localparam tmr_state_t TMR_RST = '{cnt: 32'h0, done: 1'b0};

   tmr_state_t s, next_s;

   // a fresh load always restarts the full wait
   always_comb begin
      next_s = s;
      if (load) begin
         next_s.cnt  = 32'(CYCLES - 1);
         next_s.done = 1'b0;
      end else if (s.cnt != 32'h0) begin
         next_s.cnt = s.cnt - 32'h1;
      end else begin
         next_s.done = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s <= TMR_RST;
      end else begin
         s <= next_s;
      end
   end

   assign done = s.done;
endmodule // release_timer

// ===== verilog/reset_and_power_mode_ctrl.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
// ==========================================================================
// Function
// - power control bits 7:2 are plain software read/write flags
// - writing bit 1 enters stop: processor halted, internal oscillator off
// - writing bit 0 enters idle: only processor clock gated
// - stop and idle select bits always read back zero
// - idle ends on enabled interrupt or any reset; interrupt resumes execution
// - stop ends only through an internal or external reset
// - entering reset halts execution, resets registers, disables interrupts and timers
// - reset leaves data memory untouched; stack pointer still reset
// - during reset port latches all ones, open drain, weak pull-ups on
// - reset pin driven low only during power-on and supply-monitor resets
// - reset exit clears program counter, internal clock, watchdog div 12
// - power-up waits for supply above threshold, then power-on delay
// - power-on flag set on power-on exit, cleared by other resets
// - after power-on the supply monitor is enabled and selected
// - supply below threshold holds reset until supply recovers
// - only power-on reset changes supply monitor enable state
// - supply-monitor reset release has no power-on delay
// - monitor enable reads one after power-on; status bit shows supply
module reset_and_power_mode_ctrl import rpm_pkg::*; #(
   parameter int PorDelayCycles = POR_DELAY_CYCLES
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              arst_n,
   // axi4-lite write address and data
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output wire logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output wire logic              s_axi_wready,
   // axi4-lite write response
   output wire logic [1:0]        s_axi_bresp,
   output wire logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output wire logic              s_axi_arready,
   output wire logic [31:0]       s_axi_rdata,
   output wire logic [1:0]        s_axi_rresp,
   output wire logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // supply comparator and wake/reset requests
   input  wire logic              supplyAboveRaw,
   input  wire logic              softResetReq,
   input  wire logic              irqWakeReq,
   // core control
   output wire logic              cpuReset,
   output wire logic              cpuClkEn,
   output wire logic              intOscEn,
   output wire logic              sysClkInternal,
   output wire logic              pcClear,
   output wire logic [15:0]       fetchAddr,
   output wire logic              sfrReset,
   output wire logic              wdtEnable,
   output wire logic              wdtTick,
   // reset pin (open drain) and ports
   output wire logic              rstPinOut,
   output wire logic              rstPinOe_n,
   output wire logic              portLatchOnes,
   output wire logic              portOpenDrain,
   output wire logic              weakPullupEn,
   // interrupt
   output wire logic              irq
);
   typedef struct packed {
      pwr_state_t              st;
      logic                    supSync1;
      logic                    supSync2;
      logic [PC_FLAGS_W-1:0]   gFlags;
      logic                    monEnable;
      logic                    monSelect;
      logic                    porFlag;
      logic [IRQ_W-1:0]        irqStat;
      logic [IRQ_W-1:0]        irqEn;
      logic                    cpuReset;
      logic                    cpuClkEn;
      logic                    intOscEn;
      logic                    pcClear;
      logic                    wdtEnable;
      logic                    rstPinOe_n;
      logic                    irq;
      logic                    awHeld;
      logic                    wHeld;
      logic [ADDR_W-1:0]       awAddr;
      logic [7:0]              wData;
      logic                    wStrb0;
      logic                    awready;
      logic                    wready;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    arready;
      logic                    rvalid;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
      logic                    rdPc;
   } ctrl_state_t;

   // power-up: monitor enabled and selected, chip held in reset
   localparam ctrl_state_t CTRL_RST = '{
      st: ST_POR_WAIT, supSync1: 1'b0, supSync2: 1'b0, gFlags: FLAGS_RST,
      monEnable: 1'b1, monSelect: 1'b1, porFlag: 1'b0, irqStat: IRQ_RST,
      irqEn: IRQ_RST, cpuReset: 1'b1, cpuClkEn: 1'b0, intOscEn: 1'b1,
      pcClear: 1'b0, wdtEnable: 1'b0, rstPinOe_n: 1'b0, irq: 1'b0,
      awHeld: 1'b0, wHeld: 1'b0, awAddr: '0, wData: 8'h00, wStrb0: 1'b0,
      awready: 1'b0, wready: 1'b0, bvalid: 1'b0, bresp: AXI_OKAY,
      arready: 1'b0, rvalid: 1'b0, rdata: 32'h0, rresp: AXI_OKAY, rdPc: 1'b0};

   ctrl_state_t s, next_s;
   logic        timerLoad;
   logic        timerDone;
   logic        doWrite;
   logic        monTrig;
   logic [7:0]  wIdx;

   // true for every state in which the core is held in reset
   function automatic logic inReset(input pwr_state_t st);
      return st == ST_POR_WAIT || st == ST_POR_DELAY ||
             st == ST_MON_RESET || st == ST_SW_RESET;
   endfunction

   // read mux; bits not listed read zero
   function automatic logic [31:0] readReg(input ctrl_state_t c, input logic [7:0] idx);
      logic [31:0] v;
      v = 32'h0;
      unique case (idx)
         IDX_POWER_CONTROL: v[PC_FLAGS_LSB +: PC_FLAGS_W] = c.gFlags;
         IDX_SUPPLY_MON: begin
            v[SM_EN_BIT]   = c.monEnable;
            v[SM_STAT_BIT] = c.supSync2;
         end
         IDX_RESET_SOURCE: v[RS_POR_BIT] = c.porFlag;
         IDX_IRQ_STATUS:   v[IRQ_W-1:0]  = c.irqStat;
         IDX_IRQ_ENABLE:   v[IRQ_W-1:0]  = c.irqEn;
         default:          v             = 32'h0;
      endcase
      return v;
   endfunction

   // ========================================================================
   // power-on delay and watchdog clock
   release_timer #(.CYCLES(PorDelayCycles)) u_por_timer (
      .mclk   (mclk),
      .arst_n (arst_n),
      .load   (timerLoad),
      .done   (timerDone)
   );

   tick_divider #(.DIV(WDT_DIV)) u_wdt_div (
      .mclk   (mclk),
      .arst_n (arst_n),
      .en     (s.wdtEnable),
      .tick   (wdtTick)
   );

   // ========================================================================
   // next state: bus slave, registers, sequencer
   always_comb begin
      logic [IRQ_W-1:0] events;
      logic             nextRst;
      events  = IRQ_RST;
      nextRst = 1'b0;
      next_s  = s;
      // first sync stage feeds only the second
      next_s.supSync1 = supplyAboveRaw;
      next_s.supSync2 = s.supSync1;
      monTrig   = s.monEnable && s.monSelect && !s.supSync2;
      timerLoad = 1'b0;

      // address and data are taken in either order
      if (s_axi_awvalid && s.awready) begin
         next_s.awHeld = 1'b1;
         next_s.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.wHeld  = 1'b1;
         next_s.wData  = s_axi_wdata[7:0];
         next_s.wStrb0 = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      doWrite = s.awHeld && s.wHeld && !s.bvalid;
      wIdx    = regIndex(s.awAddr);
      if (doWrite) begin
         next_s.awHeld = 1'b0;
         next_s.wHeld  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = isMapped(s.awAddr) ? AXI_OKAY : AXI_SLVERR;
      end

      // read answers on the same edge that takes the address
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rdata  = readReg(s, regIndex(s_axi_araddr));
         next_s.rresp  = isMapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
         next_s.rdPc   = regIndex(s_axi_araddr) == IDX_POWER_CONTROL;
      end

      // register writes; lane 0 carries every field
      if (doWrite && s.wStrb0 && isMapped(s.awAddr)) begin
         unique case (wIdx)
            IDX_POWER_CONTROL: begin
               next_s.gFlags = s.wData[PC_FLAGS_LSB +: PC_FLAGS_W];
               if (s.wData[PC_STOP_BIT] && s.st == ST_RUN) begin
                  next_s.st = ST_STOP;
               end else if (s.wData[PC_IDLE_BIT] && s.st == ST_RUN) begin
                  next_s.st = ST_IDLE;
               end
            end
            // select after enabling is software's duty
            IDX_RESET_SOURCE: next_s.monSelect = s.wData[RS_POR_BIT];
            IDX_SUPPLY_MON:   next_s.monEnable = s.wData[SM_EN_BIT];
            IDX_IRQ_ENABLE:   next_s.irqEn     = s.wData[IRQ_W-1:0];
            IDX_IRQ_CLEAR:    next_s.irqStat   = s.irqStat & ~s.wData[IRQ_W-1:0];
            default: ;
         endcase
      end

      // sequencer; resets outrank a mode write made in the same cycle
      unique case (s.st)
         ST_POR_WAIT: begin
            if (s.supSync2) begin
               next_s.st = ST_POR_DELAY;
               timerLoad = 1'b1;
            end
         end
         ST_POR_DELAY: begin
            if (!s.supSync2) begin
               next_s.st = ST_POR_WAIT;
            end else if (timerDone) begin
               next_s.st      = ST_RUN;
               next_s.porFlag = 1'b1;
               events[IRQ_POR_DONE] = 1'b1;
            end
         end
         ST_RUN, ST_IDLE, ST_STOP: begin
            if (monTrig) begin
               next_s.st = ST_MON_RESET;
               events[IRQ_MON_RST] = 1'b1;
            end else if (softResetReq) begin
               next_s.st = ST_SW_RESET;
            end else if (s.st == ST_IDLE && irqWakeReq) begin
               next_s.st = ST_RUN;
               events[IRQ_IDLE_WK] = 1'b1;
            end
         end
         ST_MON_RESET: begin
            if (s.supSync2) begin
               next_s.st      = ST_RUN;
               next_s.porFlag = 1'b0;
            end
         end
         ST_SW_RESET: begin
            if (monTrig) begin
               next_s.st = ST_MON_RESET;
               events[IRQ_MON_RST] = 1'b1;
            end else begin
               next_s.st      = ST_RUN;
               next_s.porFlag = 1'b0;
            end
         end
      endcase

      // register reset; memory and monitor enable kept
      nextRst = inReset(next_s.st);
      if (nextRst) begin
         next_s.gFlags = FLAGS_RST;
         next_s.irqEn  = IRQ_RST;
      end

      // core controls follow the next state
      next_s.cpuReset  = nextRst;
      next_s.cpuClkEn  = next_s.st == ST_RUN;
      next_s.intOscEn  = next_s.st != ST_STOP;
      next_s.pcClear   = inReset(s.st) && !nextRst;
      next_s.wdtEnable = !nextRst;
      // pin driven only for power and monitor resets
      next_s.rstPinOe_n = !(next_s.st == ST_POR_WAIT || next_s.st == ST_POR_DELAY ||
                            next_s.st == ST_MON_RESET);

      // set wins over a clear in the same cycle
      next_s.irqStat = next_s.irqStat | events;
      next_s.irq     = |(next_s.irqStat & next_s.irqEn);

      // one write and one read at a time
      next_s.awready = !next_s.awHeld && !next_s.bvalid;
      next_s.wready  = !next_s.wHeld && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   // ========================================================================
   // state register; power-on reset loads the defined values
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s <= CTRL_RST;
      end else begin
         s <= next_s;
      end
   end

   // ========================================================================
   // outputs
   assign s_axi_awready  = s.awready;
   assign s_axi_wready   = s.wready;
   assign s_axi_bvalid   = s.bvalid;
   assign s_axi_bresp    = s.bresp;
   assign s_axi_arready  = s.arready;
   assign s_axi_rvalid   = s.rvalid;
   assign s_axi_rdata    = s.rdata;
   assign s_axi_rresp    = s.rresp;
   assign cpuReset       = s.cpuReset;
   assign cpuClkEn       = s.cpuClkEn;
   assign intOscEn       = s.intOscEn;
   assign sysClkInternal = 1'b1;            // no other clock source in this block
   assign pcClear        = s.pcClear;
   assign fetchAddr      = RESET_VECTOR;
   assign sfrReset       = s.cpuReset;
   assign wdtEnable      = s.wdtEnable;
   assign rstPinOut      = 1'b0;            // open drain: only ever pulls low
   assign rstPinOe_n     = s.rstPinOe_n;
   assign portLatchOnes  = s.cpuReset;
   assign portOpenDrain  = s.cpuReset;
   assign weakPullupEn   = 1'b1;
   assign irq            = s.irq;

   // ========================================================================
   // assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   a_flags_store: assert property (doWrite && s.wStrb0 && wIdx == IDX_POWER_CONTROL
      && isMapped(s.awAddr) && !inReset(next_s.st) |=> s.gFlags == $past(s.wData[7:2]))
      else $error("general flags not stored");
   a_stop_entry: assert property (doWrite && s.wStrb0 && wIdx == IDX_POWER_CONTROL
      && s.wData[PC_STOP_BIT] && s.st == ST_RUN && !monTrig && !softResetReq
      && isMapped(s.awAddr) |=> !intOscEn && !cpuClkEn)
      else $error("stop not entered");
   a_idle_entry: assert property (s.st == ST_RUN && next_s.st == ST_IDLE
      |=> !cpuClkEn && intOscEn)
      else $error("idle gating wrong");
   a_mode_read: assert property (s.rvalid && s.rdPc |-> s_axi_rdata[1:0] == 2'h0)
      else $error("mode bits read nonzero");
   a_idle_wake: assert property (s.st == ST_IDLE && irqWakeReq && !monTrig
      && !softResetReq |=> cpuClkEn && s.irqStat[IRQ_IDLE_WK])
      else $error("idle did not wake");
   a_stop_hold: assert property (s.st == ST_STOP && !monTrig && !softResetReq
      |=> s.st == ST_STOP)
      else $error("stop left without reset");
   a_reset_clear: assert property (cpuReset |-> s.gFlags == FLAGS_RST
      && s.irqEn == IRQ_RST && !cpuClkEn && !wdtEnable)
      else $error("reset state not clean");
   a_port_state: assert property (cpuReset |-> portLatchOnes && portOpenDrain
      && weakPullupEn)
      else $error("ports not in reset state");
   a_pin_drive: assert property (s.st == ST_SW_RESET |-> rstPinOe_n)
      else $error("pin driven on soft reset");
   a_exit_vector: assert property ($fell(cpuReset) |-> pcClear && wdtEnable
      && fetchAddr == RESET_VECTOR)
      else $error("reset exit incomplete");
   a_por_wait: assert property ($past(s.st) == ST_POR_DELAY && s.st == ST_RUN
      |-> $past(timerDone) && s.porFlag)
      else $error("power-on released early");
   a_flag_clear: assert property (s.st == ST_SW_RESET && !monTrig |=> !s.porFlag)
      else $error("power-on flag kept");
   a_mon_trip: assert property (s.st == ST_RUN && monTrig
      |=> cpuReset && !rstPinOe_n)
      else $error("monitor reset missed");
   a_mon_kept: assert property (s.st == ST_SW_RESET |=> $stable(s.monEnable))
      else $error("monitor enable changed");
   a_mon_release: assert property (s.st == ST_MON_RESET && s.supSync2 |=> !cpuReset)
      else $error("monitor release delayed");

   c_por_exit:  cover property ($past(s.st) == ST_POR_DELAY && s.st == ST_RUN);
   c_idle_wake: cover property (s.st == ST_IDLE ##1 s.st == ST_RUN);
   c_stop_mon:  cover property (s.st == ST_STOP ##1 s.st == ST_MON_RESET);
   c_soft_rst:  cover property (s.st == ST_SW_RESET ##1 s.st == ST_RUN);
endmodule // reset_and_power_mode_ctrl

// ===== verification/reset_and_power_mode_ctrl_bench.sv
`timescale 1ns/1ps
// ==========================================================================
// bench: power-on checks first, then register rows, then reset and power mode cases
module reset_and_power_mode_ctrl_bench import rpm_pkg::*; ;
   // short delay keeps the power-on wait cheap in simulation
   localparam int POR = 20;
   typedef struct {logic [7:0] idx; logic wr; logic [7:0] wd, msk, exp; logic [1:0] rsp;} row_t;
   logic              mclk = 1'b0, arst_n = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0]        s_axi_wstrb = 4'h1;
   logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
   logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic              s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, weakPullupEn;
   logic              supplyAboveRaw = 1'b1, softResetReq = 1'b0, irqWakeReq = 1'b0;
   logic              cpuReset, cpuClkEn, intOscEn, sysClkInternal, pcClear, sfrReset;
   logic              wdtEnable, wdtTick, rstPinOut, rstPinOe_n, portLatchOnes, portOpenDrain;
   logic [15:0]       fetchAddr;
   int                fails = 0, num_checks = 0, cycles = 0, n;
   row_t              rows [7];

   reset_and_power_mode_ctrl #(.PorDelayCycles(POR)) i_dut (.mclk, .arst_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supplyAboveRaw, .softResetReq,
      .irqWakeReq, .cpuReset, .cpuClkEn, .intOscEn, .sysClkInternal, .pcClear, .fetchAddr,
      .sfrReset, .wdtEnable, .wdtTick, .rstPinOut, .rstPinOe_n, .portLatchOnes,
      .portOpenDrain, .weakPullupEn, .irq);

   // ========================================================================
   // clock and hang guard
   always begin
      #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         results();
      end
   end

   // ========================================================================
   // compare and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge mclk);
      s_axi_awaddr <= {2'h0, idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
      @(posedge mclk);
      s_axi_araddr <= {2'h0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk(rd & {24'h0, m}, {24'h0, e});
   endtask
   task automatic waitRst(input logic v);
      n = 0;
      while (cpuReset !== v && n < 300) begin
         @(posedge mclk);
         n++;
      end
   endtask
   task automatic results();
      if (fails == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ========================================================================
   // main sequence
   initial begin
      rows = '{'{IDX_RESET_SOURCE, 1'b0, 8'h00, 8'h02, 8'h02, AXI_OKAY},
               '{IDX_SUPPLY_MON, 1'b0, 8'h00, 8'hc0, 8'hc0, AXI_OKAY},
               '{IDX_POWER_CONTROL, 1'b1, 8'ha8, 8'hff, 8'ha8, AXI_OKAY},
               '{IDX_POWER_CONTROL, 1'b1, 8'h54, 8'hff, 8'h54, AXI_OKAY},
               '{8'h10, 1'b1, 8'h55, 8'hff, 8'h00, AXI_SLVERR},
               '{IDX_IRQ_ENABLE, 1'b1, 8'h07, 8'h07, 8'h07, AXI_OKAY},
               '{IDX_IRQ_STATUS, 1'b0, 8'h00, 8'h01, 8'h01, AXI_OKAY}};
      repeat (12) @(posedge mclk);
      chk({cpuReset, sfrReset, rstPinOe_n, rstPinOut, portLatchOnes, portOpenDrain, weakPullupEn},
          7'h67);
      arst_n <= 1'b1;
      waitRst(1'b0);
      chk(32'(n >= POR), 32'h1);
      chk({pcClear, wdtEnable, sysClkInternal, fetchAddr}, {3'h7, RESET_VECTOR});
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            wr(rows[i].idx, rows[i].wd);
            chk(32'(rsp), 32'(rows[i].rsp));
         end
         rdChk(rows[i].idx, rows[i].msk, rows[i].exp);
         chk(32'(rsp), 32'(rows[i].rsp));
      end
      chk(32'(irq), 32'h1);
      wr(IDX_IRQ_CLEAR, 8'h07);
      chk(32'(irq), 32'h0);
      while (wdtTick !== 1'b1) @(posedge mclk);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wdtTick !== 1'b1 && n < 40);
      chk(n, WDT_DIV);
      // idle, then wake by interrupt; flags survive, select bits read zero
      wr(IDX_POWER_CONTROL, 8'h55);
      repeat (3) @(posedge mclk);
      chk({cpuClkEn, intOscEn}, 2'h1);
      rdChk(IDX_POWER_CONTROL, 8'hff, 8'h54);
      irqWakeReq <= 1'b1;
      @(posedge mclk);
      irqWakeReq <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(cpuClkEn, 1'b1);
      // stop ignores interrupts and ends only by reset
      wr(IDX_SUPPLY_MON, 8'h00);
      wr(IDX_POWER_CONTROL, 8'h56);
      repeat (3) @(posedge mclk);
      chk({cpuClkEn, intOscEn}, 2'h0);
      irqWakeReq <= 1'b1;
      @(posedge mclk);
      irqWakeReq <= 1'b0;
      repeat (3) @(posedge mclk);
      chk({cpuClkEn, intOscEn}, 2'h0);
      softResetReq <= 1'b1;
      @(posedge mclk);
      softResetReq <= 1'b0;
      waitRst(1'b1);
      chk(rstPinOe_n, 1'b1);
      waitRst(1'b0);
      repeat (3) @(posedge mclk);
      chk({cpuClkEn, intOscEn}, 2'h3);
      rdChk(IDX_POWER_CONTROL, 8'hff, 8'h00);
      rdChk(IDX_RESET_SOURCE, 8'h02, 8'h00);
      rdChk(IDX_SUPPLY_MON, 8'h80, 8'h00);
      // monitor disabled: low supply shows in status but does not reset
      supplyAboveRaw <= 1'b0;
      repeat (6) @(posedge mclk);
      chk(cpuReset, 1'b0);
      rdChk(IDX_SUPPLY_MON, 8'hc0, 8'h00);
      supplyAboveRaw <= 1'b1;
      repeat (4) @(posedge mclk);
      wr(IDX_SUPPLY_MON, 8'h80);
      wr(IDX_RESET_SOURCE, 8'h02);
      supplyAboveRaw <= 1'b0;
      waitRst(1'b1);
      chk(rstPinOe_n, 1'b0);
      supplyAboveRaw <= 1'b1;
      waitRst(1'b0);
      chk(32'(n < 8), 32'h1);
      rdChk(IDX_IRQ_STATUS, 8'h02, 8'h02);
      rdChk(IDX_SUPPLY_MON, 8'h80, 8'h80);
      // power-on reset in mid-run
      wr(IDX_SUPPLY_MON, 8'h00);
      arst_n <= 1'b0;
      @(posedge mclk);
      arst_n <= 1'b1;
      waitRst(1'b0);
      rdChk(IDX_SUPPLY_MON, 8'hc0, 8'hc0);
      rdChk(IDX_RESET_SOURCE, 8'h02, 8'h02);
      results();
   end
endmodule // reset_and_power_mode_ctrl_bench
